// ---- bench/ccf_core_assertions.sv ----
// port checker of the rate and filter core
// assumes bind onto ccf_core, one clock domain
`timescale 1ns/1ps
module ccf_core_assertions
(
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        frameSync,
    input wire logic        adcWordValid,
    input wire logic        pllEnable,
    input wire logic        micBiasHigh,
    input wire logic        analogLoop,
    input wire logic [6:0]  gainHalfDb,
    input wire logic [1:0]  dacOversamplingRatio
);
    // ==========================================================
    // write decode
    // ==========================================================
    wire logic wr = psel && penable && pwrite;
    wire logic ctrlWr = wr && paddr == ccf_pkg::OFS_CTRL1;
    wire logic osrWr = wr && paddr == ccf_pkg::OFS_OSR;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_frame_low_one: assert property ($fell(frameSync) |=> frameSync)
        else $error("frame sync low too long");
    a_word_after: assert property (!frameSync |-> ##1 adcWordValid)
        else $error("adc word late");
    a_word_pulse: assert property (adcWordValid |=> !adcWordValid)
        else $error("adc valid not a pulse");
    a_bias_follows: assert property (ctrlWr |=> micBiasHigh == $past(pwdata[3]))
        else $error("bias level wrong");
    a_loop_follows: assert property (ctrlWr |=> analogLoop == $past(pwdata[2]))
        else $error("analog loop wrong");
    a_osr_follows: assert property (osrWr |=> dacOversamplingRatio == $past(pwdata[1:0]))
        else $error("ratio code wrong");
    a_gain_legal: assert property (gainHalfDb % 3 == 0 && gainHalfDb <= 7'h6C)
        else $error("gain off the step grid");
    a_reset_state: assert property ($fell(reset) |-> frameSync && !pllEnable && dacOversamplingRatio == ccf_pkg::OSR_128)
        else $error("reset state wrong");
    // a mode change mid frame would mix two rates
    a_pll_at_frame: assert property ($changed(pllEnable) |-> !frameSync || !$past(frameSync))
        else $error("pll switched mid frame");
    c_frame: cover property ($fell(frameSync));
    c_word: cover property (adcWordValid);
    c_ctrl: cover property (ctrlWr);
endmodule : ccf_core_assertions

// ---- bench/ccf_host_model.sv ----
// host side source of modulator bits and dac words
// assumes the core's frame sync, same clock
`timescale 1ns/1ps
module ccf_host_model
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        frameSync,
    output logic      [1:0]  adcBit,
    output logic      [31:0] dacWordIn
);
    // bits toggle so no channel sits at a constant
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            adcBit    <= 2'h0;
            dacWordIn <= 32'h00000000;
        end
        else
        begin
            adcBit <= {adcBit[0], ~adcBit[1]};
            if (!frameSync)
                dacWordIn <= dacWordIn + 32'h00010001;
        end
    end
endmodule : ccf_host_model

// ---- bench/tb.sv ----
// self-checking bench of the rate and filter core
// assumes APB at 250 MHz with a zero wait slave
`timescale 1ns/1ps
module tb;
    logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, dacStream, adcWordOut;
    logic [31:0] dacWordIn, r;
    logic [1:0] adcBit, dacOversamplingRatio;
    logic [6:0] gainHalfDb;
    logic pready, pslverr, adcWordValid, dacStreamValid, frameSync, e;
    logic pllEnable, micBiasHigh, analogLoop;
    int cyc = 0, num_errors = 0, n_compared = 0, t0, t1, t2, na, nd;
    int gc[4] = '{0, 28, 29, 30};
    int gh[4] = '{0, 84, 96, 108};
    ccf_core u_ccf_core (.*);
    ccf_host_model u_ccf_host_model (.*);
    initial forever #2 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    // one APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1) num_errors++;
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic fall(output int c);
        int n;
        n = 0;
        do @(posedge clock); while (frameSync !== 1'b0 && ++n < 2000);
        if (frameSync !== 1'b0) num_errors++;
        c = cyc;
    endtask : fall
    task automatic report_and_stop;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #40000;
        num_errors++;
        report_and_stop;
    end
    initial
    begin
        repeat (20) @(posedge clock);
        reset <= 0;
        apb(0, ccf_pkg::OFS_DIVIDE, 0); check(r, 32'h00070000);
        apb(0, ccf_pkg::OFS_STATUS, 0); check(r, 32'h0000000E);
        apb(0, ccf_pkg::OFS_OSR, 0); check(r, 32'h00000000);
        fall(t0);
        na = 0;
        nd = 0;
        do
        begin
            @(posedge clock);
            na += adcWordValid;
            nd += dacStreamValid;
        end while (frameSync !== 1'b0 && cyc - t0 < 500);
        check(na, 1);
        check(nd, 128);
        check(cyc - t0, 128);
        apb(1, ccf_pkg::OFS_CTRL1, 32'h0000002E);
        apb(0, ccf_pkg::OFS_CTRL1, 0); check(r, 32'h0000002E);
        check(micBiasHigh, 1);
        check(analogLoop, 1);
        for (int i = 0; i < 4; i++)
        begin
            apb(1, ccf_pkg::OFS_GAIN, gc[i]);
            repeat (2) @(posedge clock);
            check(gainHalfDb, gh[i]);
        end
        for (int i = 1; i < 4; i++)
        begin
            apb(1, ccf_pkg::OFS_OSR, i % 3);
            apb(0, ccf_pkg::OFS_OSR, 0); check(r, i % 3);
        end
        apb(0, 8'h1C, 0); check({r[30:0], e}, 1);
        fall(t0);
        apb(1, ccf_pkg::OFS_DIVIDE, 32'h00010201);
        fall(t1);
        fall(t2);
        check(t1 - t0, 128);
        check(t2 - t1, 192);
        apb(0, ccf_pkg::OFS_CTRL1, 0); check(r, 32'h000000AE);
        apb(0, ccf_pkg::OFS_CTRL1, 0); check(r, 32'h0000002E);
        apb(0, ccf_pkg::OFS_STATUS, 0); check(r, 3);
        check(pllEnable, 1);
        apb(1, ccf_pkg::OFS_CTRL2, 32'h00000040);
        fall(t0);
        fall(t1);
        fall(t2);
        check(t2 - t1, 48);
        report_and_stop;
    end
endmodule : tb
bind ccf_core ccf_core_assertions u_ccf_core_assertions (.clock, .reset,
    .psel, .penable, .pwrite, .paddr, .pwdata, .frameSync, .adcWordValid,
    .pllEnable, .micBiasHigh, .analogLoop, .gainHalfDb,
    .dacOversamplingRatio);

// ---- design/ccf_core.sv ----
// codec rate and filter control core with APB registers
// assumes a modulator bit stream per channel and DAC words from the
// serial port, all synchronous to the 250 MHz clock
`timescale 1ns/1ps
module ccf_core
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  adcBit,
    input  wire logic [31:0] dacWordIn,
    output logic      [31:0] adcWordOut,
    output logic             adcWordValid,
    output logic      [31:0] dacStream,
    output logic             dacStreamValid,
    output logic             frameSync,
    output logic             pllEnable,
    output logic             micBiasHigh,
    output logic             analogLoop,
    output logic      [6:0]  gainHalfDb,
    output logic      [1:0]  dacOversamplingRatio
);
    // ==========================================================
    // registers
    // ==========================================================
    logic       digLoop;   // digital loopback
    logic       anaLoop;   // analog loopback
    logic       mic_bias_level;   // mic bias level select
    logic       iirSel;    // 1 selects IIR, 0 FIR
    logic       bypass;    // filter bypass
    logic       decOvf;    // sticky decimation overflow
    logic       intOvf;    // sticky interpolation overflow
    logic [6:0] divM;
    logic [3:0] divN;
    logic [2:0] divP;
    logic [1:0] osrCode;   // dac oversampling ratio code
    logic [4:0] gainCode;  // input gain amp code
    logic [2:0] sideAtt;   // sidetone shift, 0 mutes
    logic [1:0] decOvfSet; // per channel overflow events
    logic [1:0] intOvfSet;

    ccf_rate_if rate ();

    ccf_rate_gen u_rate
    (
        .clock (clock),
        .reset (reset),
        .rate  (rate)
    );

    assign rate.divM   = divM;
    assign rate.divN   = divN;
    assign rate.divP   = divP;
    assign rate.bypass = bypass;

    // ==========================================================
    // APB slave, no wait states
    // ==========================================================
    logic apbWrite;
    logic apbRead;
    logic mapped;
    assign apbWrite = psel && penable && pwrite;
    assign apbRead  = psel && penable && !pwrite;
    assign pready   = 1'b1;
    // unmapped offsets answer an error, status is read only
    always_comb
    begin
        unique case (paddr)
            ccf_pkg::OFS_CTRL1, ccf_pkg::OFS_CTRL2,
            ccf_pkg::OFS_DIVIDE, ccf_pkg::OFS_OSR,
            ccf_pkg::OFS_GAIN, ccf_pkg::OFS_SIDE,
            ccf_pkg::OFS_STATUS: mapped = 1'b1;
            default:             mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;

    // software writable control
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            digLoop  <= 1'b0;
            anaLoop  <= 1'b0;
            mic_bias_level  <= 1'b0;
            iirSel   <= 1'b0;
            bypass   <= 1'b0;
            divM     <= ccf_pkg::RST_M;
            divN     <= ccf_pkg::RST_N;
            divP     <= ccf_pkg::RST_P; // R3
            osrCode  <= ccf_pkg::OSR_128; // R9
            gainCode <= 5'h00;
            sideAtt  <= 3'h0;
        end
        else if (apbWrite)
        begin
            unique case (paddr)
                ccf_pkg::OFS_CTRL1:
                begin
                    digLoop <= pwdata[ccf_pkg::BIT_DIGLOOP]; // R17
                    anaLoop <= pwdata[ccf_pkg::BIT_ANALOOP]; // R17
                    mic_bias_level <= pwdata[ccf_pkg::BIT_MIC_BIAS_LEVEL]; // R19
                    iirSel  <= pwdata[ccf_pkg::BIT_IIRSEL];  // R12
                end
                ccf_pkg::OFS_CTRL2: bypass <= pwdata[ccf_pkg::BIT_BYPASS];
                ccf_pkg::OFS_DIVIDE:
                begin
                    // host keeps ratio and clock limits, not checked
                    divM <= pwdata[ccf_pkg::POS_M +: 7]; // R4 R6 R10
                    divN <= pwdata[ccf_pkg::POS_N +: 4]; // R4
                    divP <= pwdata[ccf_pkg::POS_P +: 3]; // R4
                end
                ccf_pkg::OFS_OSR:  osrCode  <= pwdata[1:0]; // R9
                ccf_pkg::OFS_GAIN: gainCode <= pwdata[4:0];
                ccf_pkg::OFS_SIDE: sideAtt  <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // sticky overflow flags: a read of CTRL1 clears, a new event wins
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            decOvf <= 1'b0;
            intOvf <= 1'b0;
        end
        else
        begin
            if (|decOvfSet)
                decOvf <= 1'b1; // R22
            else if (apbRead && paddr == ccf_pkg::OFS_CTRL1)
                decOvf <= 1'b0;
            if (|intOvfSet)
                intOvf <= 1'b1; // R22
            else if (apbRead && paddr == ccf_pkg::OFS_CTRL1)
                intOvf <= 1'b0;
        end
    end

    // read mux, unused bits read zero
    always_comb
    begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            ccf_pkg::OFS_CTRL1:
            begin
                prdata[ccf_pkg::BIT_DIGLOOP] = digLoop;
                prdata[ccf_pkg::BIT_ANALOOP] = anaLoop;
                prdata[ccf_pkg::BIT_MIC_BIAS_LEVEL] = mic_bias_level;
                prdata[ccf_pkg::BIT_INTOVF]  = intOvf;
                prdata[ccf_pkg::BIT_IIRSEL]  = iirSel;
                prdata[ccf_pkg::BIT_DECOVF]  = decOvf;
            end
            ccf_pkg::OFS_CTRL2: prdata[ccf_pkg::BIT_BYPASS] = bypass;
            ccf_pkg::OFS_DIVIDE:
            begin
                prdata[ccf_pkg::POS_M +: 7] = divM;
                prdata[ccf_pkg::POS_N +: 4] = divN;
                prdata[ccf_pkg::POS_P +: 3] = divP;
            end
            ccf_pkg::OFS_OSR:  prdata[1:0] = osrCode;
            ccf_pkg::OFS_GAIN: prdata[4:0] = gainCode;
            ccf_pkg::OFS_SIDE: prdata[2:0] = sideAtt;
            ccf_pkg::OFS_STATUS:
            begin
                prdata[0]   = rate.pllOn;
                prdata[3:1] = rate.liveP;
            end
            default: ;
        endcase
    end

    // ==========================================================
    // static outputs
    // ==========================================================
    // falling edge of frame sync marks the transfer start
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            frameSync <= 1'b1;
        else
            frameSync <= !rate.frameGo; // R1
    end

    // gain in half dB: 1.5 dB steps, then two extra settings
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            gainHalfDb <= 7'h00;
        else if (gainCode <= ccf_pkg::GAIN_LAST_STEP)
            gainHalfDb <= 7'(gainCode * 3); // R20
        else if (gainCode == ccf_pkg::GAIN_48DB)
            gainHalfDb <= ccf_pkg::HALFDB_48; // R20
        else
            gainHalfDb <= ccf_pkg::HALFDB_54; // R20
    end

    assign pllEnable            = rate.pllOn; // R5
    assign micBiasHigh          = mic_bias_level;    // R19
    assign analogLoop           = anaLoop;    // R17
    assign dacOversamplingRatio = osrCode;    // R9

    // ==========================================================
    // per channel decimation and interpolation
    // ==========================================================
    logic [15:0] adcWord [2];   // finished ADC words
    logic        adcReady;      // ADC words updated

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) // R8
        begin : g_chan
            logic [7:0]  onesCnt;   // ones in this frame's stream
            logic        modBit;    // modulator input after loopback
            logic [17:0] sincVal;   // sinc output before saturation
            logic [15:0] sincWord;
            logic        sincOvf;
            logic [15:0] decLine [ccf_pkg::FIR_DEC_DELAY];
            logic [15:0] intLine [ccf_pkg::FIR_INT_DELAY];
            logic [15:0] decIir;    // first order smoother state
            logic [15:0] intIir;
            logic [15:0] dacIn;     // DAC word after loop and sidetone
            logic [16:0] mixSum;
            logic [15:0] rawWord;   // DAC word before sidetone
            logic [15:0] holdWord;  // zero-order hold for the modulator
            logic signed [15:0] sideTerm;

            // analog loopback feeds DAC output back, priority over input
            assign modBit = anaLoop ? holdWord[15] == 1'b0
                                    : adcBit[ch]; // R17

            // sinc stage: count ones over 128 (32 in bypass) ticks
            always_ff @(posedge clock or posedge reset)
            begin
                if (reset)
                    onesCnt <= 8'h00;
                else if (rate.frameGo)
                    onesCnt <= 8'(rate.osTick && modBit);
                else if (rate.osTick && modBit)
                    onesCnt <= onesCnt + 1'b1; // R13
            end
            // ones to two's complement; a full run of ones overflows
            assign sincVal = bypass
                ? {onesCnt[6:0], 11'h000} - 18'h08000
                : {1'b0, onesCnt, 9'h000} - 18'h08000; // R13 R21
            assign sincOvf  = !sincVal[17] && (sincVal[16:15] != 2'b00);
            assign sincWord = sincOvf ? 16'h7FFF : sincVal[15:0];
            assign decOvfSet[ch] = rate.frameGo && sincOvf; // R22

            // FIR as linear phase delay, IIR as one pole with little delay
            always_ff @(posedge clock or posedge reset)
            begin
                if (reset)
                begin
                    decLine <= '{default: 16'h0000};
                    decIir  <= 16'h0000;
                end
                else if (rate.frameGo)
                begin
                    decLine[0] <= sincWord; // R15
                    for (int i = 1; i < ccf_pkg::FIR_DEC_DELAY; i++)
                        decLine[i] <= decLine[i-1];
                    decIir <= decIir + 16'($signed(sincWord - decIir) >>> 1);
                end
            end
            // bypass leaves only the sinc stage
            assign adcWord[ch] = bypass ? sincWord
                : iirSel ? decIir
                : decLine[ccf_pkg::FIR_DEC_DELAY-1]; // R12 R15 R21

            // DAC input: digital loopback, then sidetone mix
            assign sideTerm = (sideAtt == 3'h0) ? 16'sh0000
                : $signed(adcWord[ch]) >>> ({1'b0, sideAtt} + 4'h2); // R18
            assign rawWord = dacInRaw(ch); // R17
            assign mixSum = {rawWord[15], rawWord}
                          + {sideTerm[15], sideTerm}; // R18
            assign dacIn = (mixSum[16] != mixSum[15])
                         ? (mixSum[16] ? 16'h8000 : 16'h7FFF)
                         : mixSum[15:0];
            assign intOvfSet[ch] = rate.frameGo
                                 && (mixSum[16] != mixSum[15]); // R22

            always_ff @(posedge clock or posedge reset)
            begin
                if (reset)
                begin
                    intLine <= '{default: 16'h0000};
                    intIir  <= 16'h0000;
                end
                else if (rate.frameGo)
                begin
                    intLine[0] <= dacIn; // R15
                    for (int i = 1; i < ccf_pkg::FIR_INT_DELAY; i++)
                        intLine[i] <= intLine[i-1];
                    intIir <= intIir + 16'($signed(dacIn - intIir) >>> 1);
                end
            end

            // sinc hold: each oversampled tick repeats the filtered word
            always_ff @(posedge clock or posedge reset)
            begin
                if (reset)
                    holdWord <= 16'h0000;
                else if (rate.osTick)
                    holdWord <= bypass ? dacIn
                        : iirSel ? intIir
                        : intLine[ccf_pkg::FIR_INT_DELAY-1]; // R12 R14
            end
            assign dacStream[ch*16 +: 16] = holdWord;
        end
    endgenerate

    // raw DAC word per channel, digital loopback swaps in ADC word
    function automatic logic [15:0] dacInRaw(input int c);
        dacInRaw = digLoop ? adcWord[c] : dacWordIn[c*16 +: 16]; // R17
    endfunction : dacInRaw

    // ADC words are registered once per frame
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            adcWordOut   <= 32'h0000_0000;
            adcReady     <= 1'b0;
        end
        else
        begin
            adcReady <= rate.frameGo; // R1
            if (adcReady)
                adcWordOut <= {adcWord[1], adcWord[0]}; // R13
        end
    end

    // valid flags: ADC a one-cycle pulse, DAC high on every oversampled tick
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            adcWordValid   <= 1'b0;
            dacStreamValid <= 1'b0;
        end
        else
        begin
            adcWordValid   <= adcReady;
            dacStreamValid <= rate.osTick; // R14
        end
    end
    // passband follows frame rate since the FIR and IIR stages run on frame ticks
    // R16
endmodule : ccf_core

// ---- design/ccf_rate_gen.sv ----
// frame and oversampling tick generator from the master clock
// assumes divider values from the register core via the carrier
`timescale 1ns/1ps
module ccf_rate_gen
(
    input  wire logic clock,
    input  wire logic reset,
    ccf_rate_if.gen   rate
);
    // ==========================================================
    // dividers in force, loaded only at a frame boundary
    // ==========================================================
    logic [6:0]               liveM;   // M minus one in force
    logic [3:0]               liveN;   // N minus one in force
    logic [2:0]               liveP;   // P minus one in force
    logic                     liveByp; // bypass in force
    logic [ccf_pkg::PERIOD_W-1:0] period;    // clocks per frame
    logic [ccf_pkg::PERIOD_W-1:0] frameCnt;  // position in frame
    logic [ccf_pkg::PERIOD_W-1:0] osAcc;     // fractional tick phase
    logic [ccf_pkg::PERIOD_W-1:0] fullPeriod; // unbypassed frame
    logic                     frameEnd;

    // full rate period 16*M*N*P, coarse mode uses P = 8
    assign fullPeriod = ccf_pkg::PERIOD_W'(ccf_pkg::BASE_DIV
                        * (int'(liveM) + 1) * (int'(liveN) + 1)
                        * (int'(liveP) + 1)); // R2 R3
    // bypass shortens the frame four times
    assign period   = liveByp ? (fullPeriod >> 2) : fullPeriod; // R21
    assign frameEnd = (frameCnt >= period - 1'b1);

    // frame counter with divider load at its wrap
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            frameCnt <= '0;
            liveM    <= ccf_pkg::RST_M;
            liveN    <= ccf_pkg::RST_N;
            liveP    <= ccf_pkg::RST_P;
            liveByp  <= 1'b0;
        end
        else if (frameEnd)
        begin
            // no partial frame at a mixed rate
            frameCnt <= '0;
            liveM    <= rate.divM; // R23
            liveN    <= rate.divN;
            liveP    <= rate.divP;
            liveByp  <= rate.bypass;
        end
        else
        begin
            frameCnt <= frameCnt + 1'b1;
        end
    end

    // oversampled tick: 128 per full-rate frame, by phase accumulation
    // a fraction keeps the spacing even when M*N*P is not a multiple of 8
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            osAcc       <= '0;
            rate.osTick <= 1'b0;
        end
        else if (osAcc + ccf_pkg::PERIOD_W'(ccf_pkg::OS_RATIO)
                 >= fullPeriod)
        begin
            osAcc <= osAcc + ccf_pkg::PERIOD_W'(ccf_pkg::OS_RATIO)
                     - fullPeriod;
            rate.osTick <= 1'b1; // R14
        end
        else
        begin
            osAcc       <= osAcc + ccf_pkg::PERIOD_W'(ccf_pkg::OS_RATIO);
            rate.osTick <= 1'b0;
        end
    end

    // frame start pulse and fine mode flag
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            rate.frameGo <= 1'b0;
            rate.pllOn   <= 1'b0;
        end
        else
        begin
            rate.frameGo <= frameEnd; // R1
            // converters only; serial clocks stay on the master clock
            rate.pllOn <= (liveP != ccf_pkg::RST_P); // R5
        end
    end
    assign rate.liveP = liveP;
endmodule : ccf_rate_gen

// ---- pkg/ccf_pkg.sv ----
// constants of the codec rate and filter control core
// assumes one 250 MHz clock and an APB register port
// Behaviour
// R1: frame sync fall starts ADC and DAC transfer
// R2: fine rate is clock over 16*M*N*P
// R3: P equal 8 selects coarse, reset default
// R4: M 1-128, N 1-16, P 1-8 in one register
// R5: PLL drives converters only, serial from clock
// R6: host keeps clock over P within 10-25 MHz
// R7: host enables drivers before writing dividers
// R8: chain count 2 standalone, mode 1 or 2
// R9: oversampling ratio field bits 1:0, default 128
// R10: host keeps M multiple per oversampling ratio
// R11: host limits rate per oversampling ratio
// R12: one bit selects FIR or IIR both paths
// R13: decimate 128 to 16-bit word per channel
// R14: interpolate to 128 times sample rate
// R15: FIR delay 17 decimation, 18 interpolation
// R16: passband tracks 0.45 of frame rate
// R17: analog loopback bit 2 wins, digital bit 1; code keeps digital loopback on when both bits are set
// R18: sidetone attenuates ADC word into DAC input
// R19: bit 3 selects microphone bias level
// R20: gain 0-42 dB by 1.5, plus 48, 54
// R21: bypass bit 6 keeps sinc, frame rate x4
// R22: overflow flags bits 7 and 4, read clears
// R23: new dividers apply at frame boundary
package ccf_pkg;
    // ==========================================================
    // register offsets (byte addresses)
    // ==========================================================
    localparam logic [7:0] OFS_CTRL1  = 8'h00; // loops, filter, flags
    localparam logic [7:0] OFS_CTRL2  = 8'h04; // filter bypass
    localparam logic [7:0] OFS_DIVIDE = 8'h08; // M, N, P
    localparam logic [7:0] OFS_OSR    = 8'h0C; // dac oversampling ratio
    localparam logic [7:0] OFS_GAIN   = 8'h10; // input gain amp code
    localparam logic [7:0] OFS_SIDE   = 8'h14; // sidetone attenuation
    localparam logic [7:0] OFS_STATUS = 8'h18; // live state, read only
    // ==========================================================
    // field positions
    // ==========================================================
    localparam int BIT_DIGLOOP = 1;
    localparam int BIT_ANALOOP = 2;
    localparam int BIT_MIC_BIAS_LEVEL = 3;
    localparam int BIT_INTOVF  = 4;
    localparam int BIT_IIRSEL  = 5;
    localparam int BIT_BYPASS  = 6;
    localparam int BIT_DECOVF  = 7;
    localparam int POS_M = 0;  // 7 bits, value minus one
    localparam int POS_N = 8;  // 4 bits, value minus one
    localparam int POS_P = 16; // 3 bits, value minus one
    // ==========================================================
    // reset values and limits
    // ==========================================================
    localparam logic [6:0] RST_M = 7'h00;  // M = 1
    localparam logic [3:0] RST_N = 4'h0;   // N = 1
    localparam logic [2:0] RST_P = 3'h7;   // P = 8, coarse mode
    localparam logic [1:0] OSR_128 = 2'h0;
    localparam logic [1:0] OSR_256 = 2'h1;
    localparam logic [1:0] OSR_512 = 2'h2;
    localparam logic [4:0] GAIN_LAST_STEP = 5'h1C; // 42 dB
    localparam logic [4:0] GAIN_48DB = 5'h1D;
    localparam logic [4:0] GAIN_54DB = 5'h1E;
    localparam logic [6:0] HALFDB_48 = 7'h60;
    localparam logic [6:0] HALFDB_54 = 7'h6C;
    localparam int BASE_DIV   = 16;  // clocks per unit of M*N*P
    localparam int OS_RATIO   = 128; // oversampled ticks per frame
    localparam int BYP_FACTOR = 4;   // frame rate gain in bypass
    localparam int FIR_DEC_DELAY = 17;
    localparam int FIR_INT_DELAY = 18;
    localparam int PERIOD_W   = 20;  // holds 16*128*16*8
endpackage : ccf_pkg

// ---- pkg/ccf_rate_if.sv ----
// carrier between the register core and the rate generator
// assumes both ends on the same clock
`timescale 1ns/1ps
interface ccf_rate_if;
    logic [6:0] divM;     // programmed M minus one
    logic [3:0] divN;     // programmed N minus one
    logic [2:0] divP;     // programmed P minus one
    logic       bypass;   // filters bypassed, frames four times faster
    logic       frameGo;  // one cycle pulse at frame start
    logic       osTick;   // oversampled converter tick
    logic       pllOn;    // fine mode active
    logic [2:0] liveP;    // P minus one in force this frame
    modport gen  (input divM, divN, divP, bypass,
                  output frameGo, osTick, pllOn, liveP);
    modport core (output divM, divN, divP, bypass,
                  input frameGo, osTick, pllOn, liveP);
endinterface : ccf_rate_if
